// ---- rtl/hbis_map.svh ----
// Functional notes
// - subtract immediate from upper byte only
// - negative flag equals result bit fifteen
// - zero flag when whole result zero
// - overflow from old, immediate, new sign
// - carry reports borrow out of bit fifteen
`ifndef HBIS_MAP_SVH
`define HBIS_MAP_SVH
`define HBIS_OPCODE_MSB      15
`define HBIS_OPCODE_LSB      11
`define HBIS_OPCODE_VALUE    5'h12
`define HBIS_RD_MSB          10
`define HBIS_RD_LSB          8
`define HBIS_IMM_MSB         7
`define HBIS_IMM_LSB         0
`define HBIS_WORD_RESET      16'h0000
`define HBIS_SEL_RESET       3'h0
`endif

// ---- rtl/hbis_pkg.sv ----
package hbis_pkg;
  // condition flags produced by the instruction
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } hbis_flags_t;
  // register write-back request
  typedef struct packed {
    logic        we;
    logic [2:0]  sel;
    logic [15:0] data;
  } hbis_wb_t;
  // pipeline state
  typedef enum logic [1:0] {
    HBIS_IDLE = 2'b01,
    HBIS_DONE = 2'b10
  } hbis_state_t;
endpackage

// ---- rtl/hbis_core.sv ----
`timescale 1ns/1ps
`include "hbis_map.svh"
module hbis_core
  import hbis_pkg::*;
#(
  parameter int DATA_W = 16, // register and result width
  parameter int IMM_W  = 8,  // immediate byte width
  parameter int SEL_W  = 3   // destination index width
)
(
  input  wire logic              sys_clk_in,    // core clock
  input  wire logic              resetn_in,     // asynchronous reset
  input  wire logic              insn_valid_in, // word present
  input  wire logic [DATA_W-1:0] insn_word_in,  // instruction word
  input  wire logic [DATA_W-1:0] rd_value_in,   // destination value now
  output logic      [SEL_W-1:0]  rd_sel_out,    // registered field copy
  output logic                   wb_en_out,     // write-back strobe
  output logic      [SEL_W-1:0]  wb_sel_out,    // write-back index
  output logic      [DATA_W-1:0] wb_data_out,   // write-back value
  output logic                   flags_en_out,  // flags update strobe
  output hbis_flags_t            flags_out,     // n, z, v, c
  output logic                   done_out       // instruction finished
);

  // the packed carriers fix the widths; refuse any other choice
  generate
    if (DATA_W != 16 || IMM_W != 8 || SEL_W != 3)
    begin : g_bad_width
      $error("hbis_core widths must be 16, 8 and 3");
    end
  endgenerate

  // reset release synchroniser
  logic              rst_meta;      // first stage, read only by rst_n
  logic              rst_n;         // released copy used by all state
  // sequencing state
  hbis_state_t       state;         // idle or just finished
  hbis_state_t       next_state;    // state after this edge
  // write-back request
  hbis_wb_t          wb;            // registered request
  hbis_wb_t          next_wb;       // request formed this cycle
  // condition flags
  hbis_flags_t       flags;         // last flags produced
  hbis_flags_t       next_flags;    // flags after this edge
  logic              flags_en;      // one-cycle update strobe
  logic              next_flags_en; // strobe for the next cycle
  // register field copy
  logic [SEL_W-1:0]  rd_sel;        // last register field seen
  logic [SEL_W-1:0]  next_rd_sel;   // field of the present word
  // decode and datapath helpers
  logic              hit;           // valid word with matching opcode
  logic [SEL_W-1:0]  dest;          // destination field
  logic [IMM_W-1:0]  imm;           // signed immediate byte
  logic [DATA_W-1:0] subtrahend;    // immediate moved to the upper byte
  logic [DATA_W-1:0] res;           // full-width result
  logic [DATA_W-1:0] ones_seen;     // running or of result bits
  logic              old_sign;      // register top bit before
  logic              imm_sign;      // immediate top bit
  logic              new_sign;      // result top bit

  // two-stage release of the asynchronous reset: assertion is at once,
  // removal waits two edges so no flop leaves reset near a clock edge
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // opcode match; a word without valid is never taken
  assign hit = insn_valid_in &&
    (insn_word_in[`HBIS_OPCODE_MSB:`HBIS_OPCODE_LSB]
     == `HBIS_OPCODE_VALUE);
  // register field and immediate byte
  assign dest = insn_word_in[`HBIS_RD_MSB:`HBIS_RD_LSB];
  assign imm  = insn_word_in[`HBIS_IMM_MSB:`HBIS_IMM_LSB];
  // immediate sits in the upper byte, lower byte zero
  assign subtrahend = {imm, {(DATA_W-IMM_W){1'b0}}};
  // lower byte of the register passes through unchanged
  assign res = rd_value_in - subtrahend;
  // sign bits that feed overflow and borrow
  assign old_sign = rd_value_in[DATA_W-1];
  assign imm_sign = imm[IMM_W-1];
  assign new_sign = res[DATA_W-1];

  // ripple or of the result bits, one stage per bit
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_zero
      if (gi == 0)
      begin : g_first
        // the chain starts at bit zero
        assign ones_seen[gi] = res[gi];
      end
      else
      begin : g_rest
        // each bit adds itself to what lies below
        assign ones_seen[gi] = ones_seen[gi-1] | res[gi];
      end
    end
  endgenerate

  // next sequencing state: done for one cycle after a taken word
  always_comb
  begin
    next_state = HBIS_IDLE;
    case (state)
      HBIS_IDLE, HBIS_DONE:
      begin
        // back-to-back words are legal from either state
        if (hit)
        begin
          next_state = HBIS_DONE;
        end
        else
        begin
          next_state = HBIS_IDLE;
        end
      end
      default:
      begin
        // unreachable code: return to idle
        next_state = HBIS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= HBIS_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // next write-back request and register field copy; the register
  // file must forward or write before a back-to-back read of the
  // same register, else the second word sees the old value
  always_comb
  begin
    // no write unless a word is taken; data reads zero when idle
    next_wb     = '0;
    next_rd_sel = dest;
    if (hit)
    begin
      // single cycle: result registered on the taking edge
      next_wb.we   = 1'b1;
      next_wb.sel  = dest;
      next_wb.data = res;
    end
  end

  // write-back and field registers
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // no pending write after reset
      wb     <= '{we: 1'b0, sel: `HBIS_SEL_RESET,
                  data: `HBIS_WORD_RESET};
      rd_sel <= `HBIS_SEL_RESET;
    end
    else
    begin
      wb     <= next_wb;
      rd_sel <= next_rd_sel;
    end
  end

  // next flags and their update strobe
  always_comb
  begin
    // flags hold between instructions
    next_flags    = flags;
    next_flags_en = 1'b0;
    if (hit)
    begin
      next_flags.n  = new_sign;
      next_flags.z  = ~ones_seen[DATA_W-1];
      // signs differ and the result left the old sign
      next_flags.v  = (old_sign ^ imm_sign)
                      & (new_sign ^ old_sign);
      // borrow out of the top bit
      next_flags.c  = (~old_sign & imm_sign)
                      | (~old_sign & new_sign)
                      | (imm_sign & new_sign);
      next_flags_en = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // flags read clear until the first instruction
      flags    <= '0;
      flags_en <= 1'b0;
    end
    else
    begin
      flags    <= next_flags;
      flags_en <= next_flags_en;
    end
  end

  // outputs come straight from flip-flops
  // field copy
  assign rd_sel_out   = rd_sel;
  // write-back request
  assign wb_en_out    = wb.we;
  assign wb_sel_out   = wb.sel;
  assign wb_data_out  = wb.data;
  // flags and their strobe
  assign flags_en_out = flags_en;
  assign flags_out    = flags;
  // done is the one-hot done bit of the state register
  assign done_out     = state[1];
endmodule

// ---- sim/hbis_properties.sv ----
`timescale 1ns/1ps
`include "hbis_map.svh"
module hbis_chk
  import hbis_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  input wire logic        insn_valid_in,
  input wire logic [15:0] insn_word_in,
  input wire logic [15:0] rd_value_in,
  input wire logic        wb_en_out,
  input wire logic [2:0]  wb_sel_out,
  input wire logic [15:0] wb_data_out,
  input wire logic        flags_en_out,
  input wire hbis_flags_t flags_out,
  input wire logic        done_out
);
  // reference result and flags, formed from the rules alone
  wire logic [15:0] r = rd_value_in - {insn_word_in[7:0], 8'h00};
  wire logic signed [16:0] wide = $signed(rd_value_in)
    - $signed({insn_word_in[7:0], 8'h00});
  wire logic s  = r[15];                  // expected sign
  wire logic ez = (r == 16'h0000);        // expected zero
  wire logic ev = wide[16] ^ wide[15];    // signed overflow
  wire logic ec = rd_value_in < {insn_word_in[7:0], 8'h00}; // borrow
  wire logic [2:0] sel = insn_word_in[10:8];
  wire logic [7:0] low = rd_value_in[7:0];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // a taken word, and a cycle that takes none
  sequence s_hit;
    insn_valid_in && insn_word_in[15:11] == `HBIS_OPCODE_VALUE;
  endsequence
  sequence s_idle;
    !(insn_valid_in && insn_word_in[15:11] == `HBIS_OPCODE_VALUE);
  endsequence
  // all three strobes at once
  sequence s_pulse;
    wb_en_out && flags_en_out && done_out;
  endsequence
  property p_n; s_hit |=> flags_out.n == $past(s); endproperty
  a_n: assert property (p_n) else $error("bad n");
  property p_z; s_hit |=> flags_out.z == $past(ez); endproperty
  a_z: assert property (p_z) else $error("bad z");
  property p_skip; !insn_valid_in |=> !wb_en_out; endproperty
  a_skip: assert property (p_skip) else $error("bad pulse");
  property p_v; s_hit |=> flags_out.v == $past(ev); endproperty
  a_v: assert property (p_v) else $error("bad v");
  property p_c; s_hit |=> flags_out.c == $past(ec); endproperty
  a_c: assert property (p_c) else $error("bad c");
  property p_data;
    s_hit |=> wb_data_out == $past(r) && wb_sel_out == $past(sel);
  endproperty
  a_data: assert property (p_data) else $error("bad result");
  property p_low; s_hit |=> wb_data_out[7:0] == $past(low); endproperty
  a_low: assert property (p_low) else $error("bad low byte");
  property p_pulse; s_hit |=> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("no strobe");
  property p_drop;
    s_hit ##1 s_idle |=> !wb_en_out && !flags_en_out && !done_out;
  endproperty
  a_drop: assert property (p_drop) else $error("long strobe");
  property p_hold;
    s_idle |=> $stable(flags_out) && wb_data_out == 16'h0000;
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved");
endmodule
bind hbis_core hbis_chk chk_i (.sys_clk_in, .resetn_in, .insn_valid_in,
  .insn_word_in, .rd_value_in, .wb_en_out, .wb_sel_out, .wb_data_out,
  .flags_en_out, .flags_out, .done_out);

// ---- sim/hbis_regfile.sv ----
`timescale 1ns/1ps
module hbis_regfile (
  input  wire logic        sys_clk_in,
  input  wire logic [2:0]  rd_sel_in,
  input  wire logic        wb_en_in,
  input  wire logic [2:0]  wb_sel_in,
  input  wire logic [15:0] wb_data_in,
  output logic [15:0]      rd_value_out
);
  // eight registers, cleared at start
  logic [15:0] regs [8] = '{default: 16'h0000};
  assign rd_value_out = regs[rd_sel_in];
  // write-back pulse lands here
  always @(posedge sys_clk_in)
    if (wb_en_in)
      regs[wb_sel_in] <= wb_data_in;
endmodule

// ---- sim/test_high_byte_immediate_subtract.sv ----
`timescale 1ns/1ps
module test_high_byte_immediate_subtract import hbis_pkg::*;;
  logic clk = 1'b0, resetn = 1'b0, vld = 1'b0, en, fen, done;
  logic [15:0] w = 16'h0000, rv, d;
  logic [2:0] rs, ws;
  hbis_flags_t f;
  // rows: enable, word, result, flags
  logic [36:0] t [6] = '{{1'b1, 16'h9101, 16'hff00, 4'h9},
    {1'b0, 16'h9901, 16'h0000, 4'h0}, {1'b1, 16'h9180, 16'h7f00, 4'h0},
    {1'b1, 16'h917f, 16'h0000, 4'h4}, {1'b1, 16'h9280, 16'h8000, 4'hb},
    {1'b1, 16'h9201, 16'h7f00, 4'h2}};
  int n_errors = 0, checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  hbis_core DUT (.sys_clk_in(clk), .resetn_in(resetn), .insn_valid_in(vld),
    .insn_word_in(w), .rd_value_in(rv), .rd_sel_out(rs), .wb_en_out(en),
    .wb_sel_out(ws), .wb_data_out(d), .flags_en_out(fen), .flags_out(f),
    .done_out(done));
  hbis_regfile model (.sys_clk_in(clk), .rd_sel_in(w[10:8]), .wb_en_in(en),
    .wb_sel_in(ws), .wb_data_in(d), .rd_value_out(rv));
  task chk(input logic ok);
    checks++;
    n_errors += (ok !== 1'b1);
    if (ok !== 1'b1)
      $display("unexpected at %0t: wrong output", $time);
  endtask
  task tally_and_finish;
    n_errors += (cyc >= 100);
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // cuts a hang short
  always @(posedge clk)
    if (++cyc == 100)
      tally_and_finish;
  initial
  begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk(en === 1'b0 && f === 4'h0 && d === 16'h0000);
    foreach (t[k])
    begin
      w = t[k][35:20];
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      chk(en === t[k][36] && fen === t[k][36] && done === t[k][36]);
      chk(d === t[k][19:4] && (!t[k][36] || ws === w[10:8]));
      chk(rs === w[10:8]);
      chk(!t[k][36] || f === t[k][3:0]);
      @(negedge clk);
      $display("row %0d done", k);
    end
    // back to back on two registers
    w = 16'h9303;
    vld = 1'b1;
    @(negedge clk);
    chk(en === 1'b1 && d === 16'hfd00 && ws === 3'h3 && f === 4'h9);
    w = 16'h9480;
    @(negedge clk);
    vld = 1'b0;
    chk(en === 1'b1 && d === 16'h8000 && ws === 3'h4 && f === 4'hb);
    @(negedge clk);
    chk(en === 1'b0 && fen === 1'b0 && d === 16'h0000 && f === 4'hb);
    $display("back to back done");
    // matching word without valid is ignored
    w = 16'h9101;
    @(negedge clk);
    chk(en === 1'b0 && done === 1'b0 && f === 4'hb);
    $display("no valid done");
    // reset in mid-run clears every output
    resetn = 1'b0;
    @(negedge clk);
    chk(en === 1'b0 && f === 4'h0 && d === 16'h0000 && rs === 3'h0);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    chk(en === 1'b1 && d === 16'hff00 && f === 4'h9);
    $display("reset done");
    tally_and_finish;
  end
endmodule
